// ---- dv/eth_node.sv ----
// far-side node model: sends one frame a byte per clock
`timescale 1ns/1ns
`default_nettype none
module eth_node (
   input  wire logic       clk,
   output var  logic       vld,
   output var  logic       sof,
   output var  logic       eof,
   output var  logic [7:0] dat,
   output var  logic       pass
);
   logic [7:0] fr [0:15];

   // idle lines at time zero
   initial begin
      vld = 1'h0;
      sof = 1'h0;
      eof = 1'h0;
      dat = 8'h0;
      pass = 1'h0;
   end

   // bytes after each edge; released dat and pass show inverted last value, vld, sof and eof go low
   task send(input int n, input bit p);
      for (int k = 0; k < n; k++) begin
         @(posedge clk);
         vld <= 1'h1;
         sof <= k == 0;
         eof <= k == n - 1;
         dat <= fr[k];
         pass <= p;
      end
      @(posedge clk);
      vld <= 1'h0;
      sof <= 1'h0;
      eof <= 1'h0;
      dat <= ~fr[n-1];
      pass <= ~p;
   endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the wake-up frame filter
`timescale 1ns/1ns
`default_nettype none
`define CHK(n,e,a) begin total_checks++; if ((e) !== (a)) begin errors++; \
   $display("wrong value %s exp %h got %h", n, e, a); end end
module tb;
   localparam int STEP = 20;
   logic        CORE_CLK = 0, RST_B = 0, SUSPEND = 0;
   logic        WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
   logic [6:0]  WB_ADR_I = 0;
   logic [3:0]  WB_SEL_I = 0, sel = 4'hf;
   logic [31:0] WB_DAT_I = 0, WB_DAT_O, cs;
   logic        WB_ACK_O, RX_VALID, RX_SOF, RX_EOF, RX_MCAST_PASS;
   logic        WAKE_REQ, IRQ, REPLY_VALID;
   logic [7:0]  RX_DATA;
   logic [4:0]  REPLY_PAGE;
   logic [1:0]  REPLY_TYPE, ty = 0;
   logic [15:0] REPLY_CSUM;
   logic [47:0] nd;
   logic [31:0] rd_q[$];
   logic [22:0] rep_q[$];
   logic [22:0] rep_seen;
   int          errors = 0, total_checks = 0, cycles = 0;

   wakeup_frame_filter #(.STEP_CYCLES(32'h14)) i_dut (.*);
   eth_node i_node (.clk(CORE_CLK), .vld(RX_VALID), .sof(RX_SOF),
      .eof(RX_EOF), .dat(RX_DATA), .pass(RX_MCAST_PASS));

   always #25 CORE_CLK = ~CORE_CLK;

   // reply fields as one word for the compare
   assign rep_seen = {REPLY_PAGE, REPLY_TYPE, REPLY_CSUM};

   // timeout, then compare read data and replies with oldest notes
   always @(posedge CORE_CLK) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         results();
      end
      if (WB_ACK_O === 1'h1 && !WB_WE_I)
         `CHK("read", rd_q.pop_front(), WB_DAT_O)
      if (REPLY_VALID === 1'h1) begin
         `CHK("reply due", 1'h1, rep_q.size() != 0)
         `CHK("reply", rep_q.pop_front(), rep_seen)
      end
   end

   function [15:0] crc(input [15:0] c, input [7:0] d);
      crc = c ^ {8'h0, d};
      for (int b = 0; b < 8; b++)
         crc = crc[0] ? (crc >> 1) ^ 16'ha001 : crc >> 1;
   endfunction

   // one classic bus cycle; a read notes d as expected data
   task wb(input bit w, input [4:0] i, input [31:0] d);
      @(posedge CORE_CLK);
      WB_CYC_I <= 1'h1;
      WB_STB_I <= 1'h1;
      WB_WE_I <= w;
      WB_SEL_I <= w ? sel : 4'hf;
      WB_ADR_I <= {i, 2'h0};
      WB_DAT_I <= w ? d : $urandom;
      if (!w) rd_q.push_back(d);
      do @(posedge CORE_CLK); while (WB_ACK_O !== 1'h1);
      WB_CYC_I <= 1'h0;
      WB_STB_I <= 1'h0;
   endtask

   // set up set 1 (set 0 as partner), send one frame, check outcome
   task run(input [3:0] cmd, input [31:0] ctl, input [2:0] kind,
            input bit good, input bit cum, input [1:0] ex);
      logic [47:0] da;
      logic [15:0] c;
      logic [4:0]  pg;
      da = kind == 3'h0 ? nd : kind == 3'h2 ? 48'hffff_ffff_ffff :
           kind == 3'h1 ? nd ^ 48'h0100_0000_0000 : nd | 48'h1;
      pg = $urandom;
      for (int k = 0; k < 14; k++)
         i_node.fr[k] = k < 6 ? da[8*k +: 8] : $urandom;
      i_node.fr[6][0] = 1'h1;
      c = crc(cum ? crc(16'hffff, i_node.fr[6]) : 16'hffff, i_node.fr[8]);
      wb(1'h1, 5'h08, {c, 16'h0});
      if (ctl[1]) wb(1'h1, 5'h09, {16'h0, c});
      wb(1'h1, 5'h0e, {8'h0, {2{i_node.fr[8]}}, 8'h0});
      wb(1'h1, 5'h12, {17'h0, ty, pg, 8'h0});
      wb(1'h1, 5'h10, {20'h0, 3'h0, ctl[1], cmd, 4'h1});
      wb(1'h1, 5'h11, ctl);
      if (!good) i_node.fr[8] = ~i_node.fr[8];
      @(posedge CORE_CLK);
      SUSPEND <= 1'h1;
      i_node.send(14, kind != 3'h4);
      if (ex[1]) begin
         rep_q.push_back({pg, ty, ty == 2'h1 ? cs[15:0] :
                          ty == 2'h2 ? cs[31:16] : 16'h0});
         ty++;
      end
      repeat (4) @(posedge CORE_CLK);
      wb(1'h0, 5'h17, {30'h0, ex});
      `CHK("irq", ex[0], IRQ)
      `CHK("wake", ex[0] && ctl[18:16] == 3'h0, WAKE_REQ)
      repeat (STEP * ctl[18:16]) @(posedge CORE_CLK);
      `CHK("wake late", ex[0], WAKE_REQ)
      SUSPEND <= 1'h0;
      wb(1'h1, 5'h17, 32'h3);
      $display("case done cmd %h ctl %h", cmd, ctl);
   endtask

   task results;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // reset, register checks, then the frame table
   initial begin
      void'($urandom(32'hecc1e825));
      repeat (2) @(posedge CORE_CLK);
      RST_B <= 1'h1;
      nd = {$urandom, $urandom} & ~48'h1;
      cs = $urandom;
      wb(1'h0, 5'h11, 32'h0);
      wb(1'h0, 5'h17, 32'h0);
      wb(1'h1, 5'h1f, cs);
      wb(1'h0, 5'h1f, 32'h0);
      wb(1'h1, 5'h00, 32'h1);
      sel = 4'h1;
      wb(1'h1, 5'h01, 32'hffff_ff01);
      sel = 4'hf;
      wb(1'h0, 5'h01, 32'h1);
      wb(1'h1, 5'h0c, 32'h0000_0403);
      wb(1'h1, 5'h15, nd[31:0]);
      wb(1'h1, 5'h16, {16'h0, nd[47:32]});
      wb(1'h1, 5'h14, cs);
      wb(1'h1, 5'h18, 32'h1);
      wb(1'h0, 5'h18, 32'h1);
      run(4'h9, 32'h0, 3'h1, 1, 0, 2'h3);
      run(4'h9, 32'h0, 3'h1, 0, 0, 2'h0);
      run(4'h8, 32'h0, 3'h1, 1, 0, 2'h0);
      run(4'h3, 32'h0, 3'h1, 1, 0, 2'h0);
      run(4'h3, 32'h0, 3'h0, 1, 0, 2'h1);
      run(4'h5, 32'h0, 3'h0, 1, 0, 2'h0);
      run(4'h5, 32'h0, 3'h4, 1, 0, 2'h0);
      run(4'hd, 32'h0, 3'h3, 1, 0, 2'h3);
      run(4'h0, 32'h100, 3'h0, 0, 0, 2'h1);
      run(4'h0, 32'h200, 3'h3, 0, 0, 2'h1);
      run(4'h1, 32'h0200_0000, 3'h1, 1, 0, 2'h0);
      run(4'h9, 32'h0200_0000, 3'h2, 1, 0, 2'h3);
      run(4'h1, 32'h1, 3'h1, 1, 0, 2'h0);
      run(4'h9, 32'h1, 3'h1, 1, 1, 2'h3);
      run(4'h1, 32'h0, 3'h1, 1, 1, 2'h0);
      run(4'h1, 32'h3, 3'h1, 1, 1, 2'h1);
      run(4'h1, 32'h0003_0000, 3'h1, 1, 0, 2'h1);
      `CHK("replies left", 0, rep_q.size())
      results();
   end
endmodule
`default_nettype wire

// ---- dv/wf_asserts.sv ----
// port-level assertions for the wake-up frame filter
`timescale 1ns/1ns
`default_nettype none
module wf_asserts (
   input wire logic        CORE_CLK,
   input wire logic        RST_B,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   input wire logic        RX_VALID,
   input wire logic        RX_EOF,
   input wire logic        SUSPEND,
   input wire logic        WAKE_REQ,
   input wire logic        IRQ,
   input wire logic        REPLY_VALID,
   input wire logic [4:0]  REPLY_PAGE
);
   logic [2:0] since_eof_r;

   // edges since the last end-of-frame byte, saturating
   always @(posedge CORE_CLK) begin
      if (!RST_B || (RX_VALID && RX_EOF))
         since_eof_r <= RST_B ? 3'h1 : 3'h7;
      else if (since_eof_r != 3'h7)
         since_eof_r <= since_eof_r + 3'h1;
   end

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);

   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   ack_resp_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack missing after request");
   ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack without request");
   read_hold_a: assert property ($changed(WB_DAT_O) |-> WB_ACK_O)
      else $error("read data changed outside ack");
   reply_pulse_a: assert property (REPLY_VALID |=> !REPLY_VALID)
      else $error("reply strobe too long");
   reply_late_a: assert property (REPLY_VALID |->
      since_eof_r inside {[2:3]})
      else $error("reply not tied to frame end");
   reply_hold_a: assert property ($changed(REPLY_PAGE) |-> REPLY_VALID)
      else $error("reply page moved without reply");
   wake_susp_a: assert property (!SUSPEND |=> !WAKE_REQ)
      else $error("wake while not suspended");
   wake_rise_a: assert property ($rose(WAKE_REQ) |-> $past(SUSPEND, 2))
      else $error("wake rose without held suspend");
   reset_out_a: assert property (disable iff (1'h0)
      !RST_B |=> !WAKE_REQ && !IRQ && !REPLY_VALID && !WB_ACK_O)
      else $error("outputs not cleared by reset");

   cover property (REPLY_VALID);
   cover property ($rose(WAKE_REQ));
   cover property ($rose(IRQ));
endmodule

bind wakeup_frame_filter wf_asserts i_chk (.*);
`default_nettype wire

// ---- rtl/wakeup_crc_lane.v ----
// one filter lane: running crc-16 and last taken byte
`timescale 1ns/1ns
`default_nettype none
`include "wakeup_filter_regs.vh"

module wakeup_crc_lane (
   input  wire        clk,
   input  wire        rst_b,
   input  wire        clear,
   input  wire        take,
   input  wire [7:0]  data,
   output reg  [15:0] crc,
   output reg  [7:0]  last
);

   // crc-16 update of one byte, lsb first
   function [15:0] crc16_byte;
      input [15:0] c;
      input [7:0]  d;
      integer      b;
      reg   [15:0] r;
      begin
         r = c;
         for (b = 0; b < 8; b = b + 1) begin
            if (r[0] ^ d[b]) begin
               r = (r >> 1) ^ `WF_CRC_POLY_REV;
            end else begin
               r = r >> 1;
            end
         end
         crc16_byte = r;
      end
   endfunction

   wire [15:0] base = clear ? `WF_CRC_INIT : crc;

   // restart at frame start, fold in each selected byte
   always @(posedge clk) begin
      if (!rst_b) begin
         crc  <= `WF_CRC_INIT;
         last <= 8'h00;
      end else if (take) begin
         crc  <= crc16_byte(base, data);
         last <= data;
      end else if (clear) begin
         crc  <= `WF_CRC_INIT;
         last <= 8'h00;
      end
   end

endmodule
`default_nettype wire

// ---- rtl/wakeup_filter_regs.vh ----
// register map, field positions and constants of the wake-up frame filter
`ifndef WAKEUP_FILTER_REGS_VH
`define WAKEUP_FILTER_REGS_VH

// word indices; byte address is four times the index
`define WF_IDX_MASK0     5'h00
`define WF_IDX_CRC0      5'h08
`define WF_IDX_OFF0      5'h0c
`define WF_IDX_LAST0     5'h0e
`define WF_IDX_CMD       5'h10
`define WF_IDX_CTRL      5'h11
`define WF_IDX_PAGE0     5'h12
`define WF_IDX_CSUM      5'h14
`define WF_ARRAY_WORDS   5'h15
`define WF_IDX_NODE_LO   5'h15
`define WF_IDX_NODE_HI   5'h16
`define WF_IDX_INT_STAT  5'h17
`define WF_IDX_INT_MASK  5'h18
`define WF_IDX_STATE     5'h19

// command nibble bits
`define WF_CMD_MASK_EN   0
`define WF_CMD_DA        1
`define WF_CMD_MC        2
`define WF_CMD_REPLY     3

// control word fields
`define WF_CTRL_CASC     6:0
`define WF_CTRL_DA_ONLY  8
`define WF_CTRL_MC_ONLY  9
`define WF_CTRL_TMR      18:16
`define WF_CTRL_BCAST    31:24

// reply page byte fields and types
`define WF_PAGE_FLD      4:0
`define WF_TYPE_FLD      6:5
`define WF_TYPE_RAW      2'h0
`define WF_TYPE_NA0      2'h1
`define WF_TYPE_NA1      2'h2
`define WF_TYPE_ARP      2'h3

// interrupt status bits
`define WF_INT_WAKE      0
`define WF_INT_REPLY     1

// crc-16 x^16+x^15+x^2+1, shifted lsb first
`define WF_CRC_INIT      16'hffff
`define WF_CRC_POLY_REV  16'ha001

// frame position
`define WF_DA_BYTES      10'h006
`define WF_POS_MAX       10'h3ff

// hold-off timer
`define WF_TMR_STEP_S    4
`define WF_CLK_HZ        20000000

`endif

// ---- rtl/wakeup_frame_filter.v ----
// wake-up frame filter with wishbone register access
//
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "wakeup_filter_regs.vh"

module wakeup_frame_filter #(
   parameter [31:0] STEP_CYCLES = `WF_TMR_STEP_S * `WF_CLK_HZ
) (
   input  wire        CORE_CLK,
   input  wire        RST_B,
   input  wire        WB_CYC_I,
   input  wire        WB_STB_I,
   input  wire        WB_WE_I,
   input  wire [6:0]  WB_ADR_I,
   input  wire [3:0]  WB_SEL_I,
   input  wire [31:0] WB_DAT_I,
   output reg  [31:0] WB_DAT_O,
   output reg         WB_ACK_O,
   input  wire        RX_VALID,
   input  wire        RX_SOF,
   input  wire        RX_EOF,
   input  wire [7:0]  RX_DATA,
   input  wire        RX_MCAST_PASS,
   input  wire        SUSPEND,
   output reg         WAKE_REQ,
   output reg         IRQ,
   output reg         REPLY_VALID,
   output reg  [4:0]  REPLY_PAGE,
   output reg  [1:0]  REPLY_TYPE,
   output reg  [15:0] REPLY_CSUM
);

   // byte-lane merge of a write
   function [31:0] merge_sel;
      input [31:0] old;
      input [31:0] wd;
      input [3:0]  sel;
      integer      n;
      begin
         merge_sel = old;
         for (n = 0; n < 4; n = n + 1) begin
            if (sel[n]) begin
               merge_sel[8*n +: 8] = wd[8*n +: 8];
            end
         end
      end
   endfunction

   // mask bit for frame position relative to a filter's offset
   function mask_hit;
      input [9:0]  pos;
      input [7:0]  off;
      input [31:0] mask;
      reg   [10:0] rel;
      begin
         rel      = {1'b0, pos} - {2'b00, off, 1'b0};
         mask_hit = ~rel[10] & (rel[9:5] == 5'h00) & mask[rel[4:0]];
      end
   endfunction

   reg  [31:0] wfa_r [0:20];
   reg  [31:0] node_lo_r;
   reg  [15:0] node_hi_r;
   reg  [1:0]  int_stat_r;
   reg  [1:0]  int_mask_r;
   reg  [1:0]  int_stat_nxt;
   reg  [31:0] rd_nxt;
   reg  [9:0]  pos_r;
   reg  [47:0] da_r;
   reg         mc_r;
   reg         eval_r;
   reg         susp_d_r;
   reg  [2:0]  steps_r;
   reg  [31:0] step_cnt_r;
   reg         pend_r;
   reg         rep_hit;
   reg  [2:0]  rep_sel;
   integer     k;
   integer     j;

   wire [4:0]  idx   = WB_ADR_I[6:2];
   wire        req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   wire        wr_en = req & WB_WE_I;
   wire [31:0] ctrl  = wfa_r[`WF_IDX_CTRL];
   wire [31:0] cmds  = wfa_r[`WF_IDX_CMD];
   wire [31:0] csums = wfa_r[`WF_IDX_CSUM];
   wire [7:0]  casc  = {1'b0, ctrl[`WF_CTRL_CASC]};
   wire [7:0]  bc_en = ctrl[`WF_CTRL_BCAST];
   wire        sof   = RX_VALID & RX_SOF;
   wire [9:0]  cur_pos = RX_SOF ? 10'h000 : pos_r;
   wire        masking = (steps_r != 3'h0);
   wire [31:0] node_hi_m = merge_sel({16'h0000, node_hi_r}, WB_DAT_I,
                                     WB_SEL_I);

   // destination checks on the captured address
   wire [47:0] node = {node_lo_r[7:0], node_lo_r[15:8], node_lo_r[23:16],
                       node_lo_r[31:24], node_hi_r[7:0], node_hi_r[15:8]};
   wire        da_node = (da_r == node);
   wire        da_mc   = da_r[40] & mc_r;
   wire        da_bc   = &da_r;

   wire [7:0]  own_m;
   wire [7:0]  take;
   wire [7:0]  hit;
   wire [7:0]  rep_en;
   wire [55:0] rep_cfg;
   wire [15:0] crc_o [0:7];
   wire [7:0]  last_o [0:7];

   // a byte taken by set n-1 also feeds set n when cascaded
   assign take = {8{RX_VALID}} & (own_m | {casc[6:0] & take[6:0], 1'b0});

   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_set
         wire [3:0]  cmd  = cmds[4*i +: 4];
         wire [31:0] mask = wfa_r[`WF_IDX_MASK0 + i];
         wire [15:0] want = wfa_r[`WF_IDX_CRC0 + i/2][16*(i%2) +: 16];
         wire [7:0]  off  = wfa_r[`WF_IDX_OFF0 + i/4][8*(i%4) +: 8];
         wire [7:0]  lb   = wfa_r[`WF_IDX_LAST0 + i/4][8*(i%4) +: 8];
         wire        ok;

         // own selection of this set's byte mask
         assign own_m[i] = cmd[`WF_CMD_MASK_EN]
                         & mask_hit(cur_pos, off, mask);

         wakeup_crc_lane u_lane (
            .clk   (CORE_CLK),
            .rst_b (RST_B),
            .clear (sof),
            .take  (take[i]),
            .data  (RX_DATA),
            .crc   (crc_o[i]),
            .last  (last_o[i])
         );

         // only a chain tail judges, with its own crc and last byte
         assign ok = (crc_o[i] == want) & (last_o[i] == lb);
         assign hit[i] = ~casc[i] & ok & cmd[`WF_CMD_MASK_EN]
                       & (~cmd[`WF_CMD_DA] | da_node)
                       & (~cmd[`WF_CMD_MC] | da_mc)
                       & (~bc_en[i] | da_bc);
         assign rep_en[i] = hit[i] & cmd[`WF_CMD_REPLY];
         assign rep_cfg[7*i +: 7] =
            wfa_r[`WF_IDX_PAGE0 + i/4][8*(i%4) +: 7];
      end
   endgenerate

   // any filter or match-only condition gives a wake frame
   wire any_wake = (|hit)
                 | (ctrl[`WF_CTRL_DA_ONLY] & da_node)
                 | (ctrl[`WF_CTRL_MC_ONLY] & da_mc);

   // lowest numbered replying filter wins
   always @* begin
      rep_hit = 1'b0;
      rep_sel = 3'h0;
      for (j = 7; j >= 0; j = j - 1) begin
         if (rep_en[j]) begin
            rep_hit = 1'b1;
            rep_sel = j[2:0];
         end
      end
   end

   wire [6:0] sel_cfg = rep_cfg[7*rep_sel +: 7];
   wire [1:0] sel_type = sel_cfg[`WF_TYPE_FLD];

   // frame position, destination capture, evaluation strobe
   always @(posedge CORE_CLK) begin
      if (!RST_B) begin
         pos_r  <= 10'h000;
         da_r   <= 48'h0000_0000_0000;
         mc_r   <= 1'b0;
         eval_r <= 1'b0;
      end else begin
         eval_r <= RX_VALID & RX_EOF & SUSPEND;
         if (RX_VALID) begin
            if (cur_pos != `WF_POS_MAX) begin
               pos_r <= cur_pos + 10'h001;
            end
            if (cur_pos < `WF_DA_BYTES) begin
               da_r <= {da_r[39:0], RX_DATA};
            end
            if (RX_EOF) begin
               mc_r <= RX_MCAST_PASS;
            end
         end
      end
   end

   // hold-off timer armed when suspend begins
   always @(posedge CORE_CLK) begin
      if (!RST_B) begin
         susp_d_r   <= 1'b0;
         steps_r    <= 3'h0;
         step_cnt_r <= 32'h0000_0000;
      end else begin
         susp_d_r <= SUSPEND;
         if (SUSPEND & ~susp_d_r) begin
            steps_r    <= ctrl[`WF_CTRL_TMR];
            step_cnt_r <= 32'h0000_0000;
         end else if (~SUSPEND) begin
            steps_r <= 3'h0;
         end else if (masking) begin
            if (step_cnt_r == STEP_CYCLES - 32'h0000_0001) begin
               step_cnt_r <= 32'h0000_0000;
               steps_r    <= steps_r - 3'h1;
            end else begin
               step_cnt_r <= step_cnt_r + 32'h0000_0001;
            end
         end
      end
   end

   // wake pending until suspend ends, shown after hold-off
   always @(posedge CORE_CLK) begin
      if (!RST_B) begin
         pend_r   <= 1'b0;
         WAKE_REQ <= 1'b0;
      end else begin
         if (~SUSPEND) begin
            pend_r <= 1'b0;
         end else if (eval_r & any_wake) begin
            pend_r <= 1'b1;
         end
         WAKE_REQ <= SUSPEND & pend_r & ~masking;
      end
   end

   // auto reply request toward the transmit side
   always @(posedge CORE_CLK) begin
      if (!RST_B) begin
         REPLY_VALID <= 1'b0;
         REPLY_PAGE  <= 5'h00;
         REPLY_TYPE  <= 2'h0;
         REPLY_CSUM  <= 16'h0000;
      end else begin
         REPLY_VALID <= eval_r & SUSPEND & rep_hit;
         if (eval_r & SUSPEND & rep_hit) begin
            REPLY_PAGE <= sel_cfg[`WF_PAGE_FLD];
            REPLY_TYPE <= sel_type;
            if (sel_type == `WF_TYPE_NA0) begin
               REPLY_CSUM <= csums[15:0];
            end else if (sel_type == `WF_TYPE_NA1) begin
               REPLY_CSUM <= csums[31:16];
            end else begin
               REPLY_CSUM <= 16'h0000;
            end
         end
      end
   end

   // sticky status, write one clears, new event wins
   always @* begin
      int_stat_nxt = int_stat_r;
      if (wr_en && idx == `WF_IDX_INT_STAT && WB_SEL_I[0]) begin
         int_stat_nxt = int_stat_r & ~WB_DAT_I[1:0];
      end
      if (eval_r & any_wake) begin
         int_stat_nxt[`WF_INT_WAKE] = 1'b1;
      end
      if (eval_r & SUSPEND & rep_hit) begin
         int_stat_nxt[`WF_INT_REPLY] = 1'b1;
      end
   end

   // read data selection
   always @* begin
      if (idx < `WF_ARRAY_WORDS) begin
         rd_nxt = wfa_r[idx];
      end else if (idx == `WF_IDX_NODE_LO) begin
         rd_nxt = node_lo_r;
      end else if (idx == `WF_IDX_NODE_HI) begin
         rd_nxt = {16'h0000, node_hi_r};
      end else if (idx == `WF_IDX_INT_STAT) begin
         rd_nxt = {30'h0000_0000, int_stat_r};
      end else if (idx == `WF_IDX_INT_MASK) begin
         rd_nxt = {30'h0000_0000, int_mask_r};
      end else if (idx == `WF_IDX_STATE) begin
         rd_nxt = {16'h0000, hit, 1'b0, steps_r, masking,
                   pend_r, SUSPEND, WAKE_REQ};
      end else begin
         rd_nxt = 32'h0000_0000;
      end
   end

   // filter array storage
   always @(posedge CORE_CLK) begin
      if (!RST_B) begin
         for (k = 0; k < `WF_ARRAY_WORDS; k = k + 1) begin
            wfa_r[k] <= 32'h0000_0000;
         end
      end else if (wr_en && idx < `WF_ARRAY_WORDS) begin
         wfa_r[idx] <= merge_sel(wfa_r[idx], WB_DAT_I, WB_SEL_I);
      end
   end

   // bus answer, node address, interrupt registers
   always @(posedge CORE_CLK) begin
      if (!RST_B) begin
         WB_ACK_O   <= 1'b0;
         WB_DAT_O   <= 32'h0000_0000;
         node_lo_r  <= 32'h0000_0000;
         node_hi_r  <= 16'h0000;
         int_stat_r <= 2'h0;
         int_mask_r <= 2'h0;
         IRQ        <= 1'b0;
      end else begin
         WB_ACK_O   <= req;
         int_stat_r <= int_stat_nxt;
         IRQ        <= |(int_stat_nxt & int_mask_r);
         if (req & ~WB_WE_I) begin
            WB_DAT_O <= rd_nxt;
         end
         if (wr_en && idx == `WF_IDX_NODE_LO) begin
            node_lo_r <= merge_sel(node_lo_r, WB_DAT_I, WB_SEL_I);
         end else if (wr_en && idx == `WF_IDX_NODE_HI) begin
            node_hi_r <= node_hi_m[15:0];
         end else if (wr_en && idx == `WF_IDX_INT_MASK && WB_SEL_I[0]) begin
            int_mask_r <= WB_DAT_I[1:0];
         end
      end
   end

endmodule
`default_nettype wire
